// ==== fsid_pkg.sv ====
// Package: constants and types for the flash sleep and ID readout block
package fsid_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_DEEP_SLEEP     = 8'hB9;
    localparam logic [7:0] CMD_WAKE_SIGNATURE = 8'hAB;
    localparam logic [7:0] CMD_ID_SINGLE      = 8'h90;
    localparam logic [7:0] CMD_ID_DUAL        = 8'h92;
    localparam logic [7:0] CMD_ID_QUAD        = 8'h94;

    // ------------------------------------------------------------
    // Identity values (arbitrary, not those of any real part)
    // ------------------------------------------------------------
    localparam logic [7:0] MFR_ID_VALUE       = 8'h5A;  // Arbitrary value
    localparam logic [7:0] DEV_ID_VALUE       = 8'h3C;  // Arbitrary value
    localparam logic [7:0] SIGNATURE_VALUE    = 8'h3C;  // Arbitrary value
    localparam logic [7:0] ADDR_DEV_FIRST     = 8'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 8;
    localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
    localparam int WAKE_DELAY_NS          = 8000;
    localparam int SLEEP_ENTRY_CYCLES     =
        (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES            =
        (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W                = 11;

    // ------------------------------------------------------------
    // Frame counting
    // ------------------------------------------------------------
    localparam logic [5:0] CMD_BITS       = 6'h08;
    localparam logic [5:0] PREAMBLE_BYTES = 6'h03;  // Two dummy bytes plus address

    // ------------------------------------------------------------
    // Power states and frame phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PWR_STANDBY, PWR_ENTERING, PWR_SLEEP, PWR_WAKING} fsid_pwr_t;
    typedef enum logic [2:0] {PH_CMD, PH_PRE, PH_OUT, PH_SIG, PH_IGNORE} fsid_phase_t;

    // Data line bundle
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } fsid_io_t;

endpackage : fsid_pkg

// ==== fsid_core.sv ====
// Device logic: deep sleep entry, wake, signature and ID readout
`timescale 1ns/1ps

// How it works
// - Asleep: ignore all but wake/signature
// - Sleep begins after sleep entry delay
// - Sleep commands only at eighth bit
// - Reset starts in standby, not sleep
// - Wake while awake: standby at once
// - Wake from sleep takes the wake delay
// - Signature byte returned by wake code
// - Wake blocked while write busy
// - Signature repeats until deselect
// - ID bits out on falling edge, MSB first
// - Address one swaps ID order
// - IDs alternate until deselect
// - Dual variant two bits per clock
// - Quad variant four bits per clock
// - Inputs latched on rising clock edge
// - Busy flag blocks commands during writes
module fsid_core
    import fsid_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] io_in,
    input  wire logic       write_busy_flag,
    output logic [3:0]      io_out,
    output logic [3:0]      io_oe_n,
    output logic            deep_sleep,
    output logic            standby
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] raw;
    logic       cs_st;
    logic       sck_st;
    logic [3:0] io_st;
    logic       busy_st;

    assign raw = {write_busy_flag, io_in, sclk, cs_n};

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 7'h03;  // Idle levels: deselected, link clock parked high
            s2 <= 7'h03;
            s3 <= 7'h03;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Filtered levels
    logic [6:0] filt;
    logic [6:0] next_filt;

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= 7'h03;  // Matches idle pins so no false clock edge follows reset
        end else begin
            filt <= next_filt;
        end
    end

    assign cs_st   = filt[0];
    assign sck_st  = filt[1];
    assign io_st   = filt[5:2];
    assign busy_st = filt[6];

    // Edge events from filtered levels
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;

    assign sck_rise = next_filt[1] & ~sck_st;
    assign sck_fall = ~next_filt[1] & sck_st;
    assign cs_rise  = next_filt[0] & ~cs_st;
    assign cs_fall  = ~next_filt[0] & cs_st;

    // Shift in per mode width
    function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                           input logic [1:0] w,
                                           input logic [3:0] d);
        case (w)
            2'h1:    shift_in = {cur[5:0], d[1:0]};
            2'h2:    shift_in = {cur[3:0], d};
            default: shift_in = {cur[6:0], d[0]};
        endcase
    endfunction : shift_in

    // ------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------
    fsid_phase_t phase;
    fsid_phase_t next_phase;
    logic [7:0]  sr;
    logic [7:0]  next_sr;
    logic [5:0]  bitcnt;
    logic [5:0]  next_bitcnt;
    logic [5:0]  bytecnt;
    logic [5:0]  next_bytecnt;
    logic [1:0]  width;           // 0 single, 1 dual, 2 quad
    logic [1:0]  next_width;
    logic        swap;
    logic        next_swap;
    logic [7:0]  cmd;
    logic [7:0]  next_cmd;
    logic        cmd_done;
    logic        next_cmd_done;
    logic [3:0]  next_io_out;
    logic [3:0]  next_io_oe_n;
    logic [5:0]  per_byte;

    fsid_pwr_t   pwr;
    logic        awake;

    assign awake    = (pwr == PWR_STANDBY);
    assign per_byte = (width == 2'h2) ? 6'h02 : (width == 2'h1) ? 6'h04 : 6'h08;

    always_comb begin
        next_phase    = phase;
        next_sr       = sr;
        next_bitcnt   = bitcnt;
        next_bytecnt  = bytecnt;
        next_width    = width;
        next_swap     = swap;
        next_cmd      = cmd;
        next_cmd_done = cmd_done;
        next_io_out   = io_out;
        next_io_oe_n  = io_oe_n;
        if (cs_fall) begin
            next_phase    = PH_CMD;
            next_bitcnt   = 6'h00;
            next_bytecnt  = 6'h00;
            next_width    = 2'h0;
            next_cmd_done = 1'b0;
            next_sr       = 8'h00;
        end else if (cs_rise || cs_st) begin
            next_phase   = PH_IGNORE;
            next_io_oe_n = 4'hF;
        end else if (sck_rise) begin
            case (phase)
                PH_CMD: begin
                    next_sr     = shift_in(sr, 2'h0, io_st);
                    next_bitcnt = bitcnt + 6'h01;
                    if (bitcnt + 6'h01 == CMD_BITS) begin
                        next_cmd      = next_sr;
                        next_cmd_done = 1'b1;
                        next_bitcnt   = 6'h00;
                        if (next_sr == CMD_WAKE_SIGNATURE && !busy_st) begin
                            next_phase = PH_SIG;
                            next_sr    = SIGNATURE_VALUE;
                        end else if (!awake || busy_st) begin
                            next_phase = PH_IGNORE;
                        end else if (next_sr == CMD_ID_SINGLE) begin
                            next_phase = PH_PRE;
                        end else if (next_sr == CMD_ID_DUAL) begin
                            next_phase = PH_PRE;
                            next_width = 2'h1;
                        end else if (next_sr == CMD_ID_QUAD) begin
                            next_phase = PH_PRE;
                            next_width = 2'h2;
                        end else begin
                            next_phase = PH_IGNORE;
                        end
                    end
                end
                PH_PRE: begin
                    next_sr     = shift_in(sr, width, io_st);
                    next_bitcnt = bitcnt + 6'h01;
                    if (bitcnt + 6'h01 == per_byte) begin
                        next_bitcnt  = 6'h00;
                        next_bytecnt = bytecnt + 6'h01;
                        if (bytecnt + 6'h01 == PREAMBLE_BYTES) begin
                            next_swap  = (next_sr == ADDR_DEV_FIRST);
                            next_sr    = (next_sr == ADDR_DEV_FIRST) ? DEV_ID_VALUE
                                                                     : MFR_ID_VALUE;
                            next_phase = PH_OUT;
                        end
                    end
                end
                PH_OUT, PH_SIG: begin
                    next_cmd_done = 1'b0;  // Extra clocks clear cmd_done; a sleep code sits in PH_IGNORE and is cleared below
                end
                default: begin
                    next_cmd_done = 1'b0;
                end
            endcase
        end else if (sck_fall) begin
            case (phase)
                PH_OUT, PH_SIG: begin
                    next_io_oe_n = (width == 2'h2) ? 4'h0 : (width == 2'h1) ? 4'hC : 4'hD;
                    if (width == 2'h2) begin
                        next_io_out = sr[7:4];
                        next_sr     = {sr[3:0], 4'h0};
                    end else if (width == 2'h1) begin
                        next_io_out = {2'h0, sr[7:6]};
                        next_sr     = {sr[5:0], 2'h0};
                    end else begin
                        next_io_out = {2'h0, sr[7], 1'b0};     // Single line on io_line1
                        next_sr     = {sr[6:0], 1'b0};
                    end
                    next_bitcnt = bitcnt + 6'h01;
                    if (bitcnt + 6'h01 == per_byte) begin
                        next_bitcnt  = 6'h00;
                        next_bytecnt = bytecnt + 6'h01;
                        if (phase == PH_SIG) begin
                            next_sr = SIGNATURE_VALUE;
                        end else begin
                            next_swap = ~swap;
                            next_sr   = swap ? MFR_ID_VALUE : DEV_ID_VALUE;
                        end
                    end
                end
                default: begin
                    next_io_oe_n = 4'hF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase    <= PH_IGNORE;
            sr       <= 8'h00;
            bitcnt   <= 6'h00;
            bytecnt  <= 6'h00;
            width    <= 2'h0;
            swap     <= 1'b0;
            cmd      <= 8'h00;
            cmd_done <= 1'b0;
            io_out   <= 4'h0;
            io_oe_n  <= 4'hF;
        end else begin
            phase    <= next_phase;
            sr       <= next_sr;
            bitcnt   <= next_bitcnt;
            bytecnt  <= next_bytecnt;
            width    <= next_width;
            swap     <= next_swap;
            cmd      <= next_cmd;
            cmd_done <= next_cmd_done;
            io_out   <= next_io_out;
            io_oe_n  <= next_io_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    fsid_pwr_t          next_pwr;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic               sleep_req;
    logic               wake_req;

    // Sleep valid only when deselect lands right after the eighth bit; wake also after signature clocks
    assign sleep_req = cs_rise && cmd_done && cmd == CMD_DEEP_SLEEP && !busy_st;
    assign wake_req  = cs_rise && cmd == CMD_WAKE_SIGNATURE && !busy_st &&
                       (cmd_done || phase == PH_SIG);

    always_comb begin
        next_pwr   = pwr;
        next_timer = timer;
        case (pwr)
            PWR_STANDBY: begin
                if (sleep_req) begin
                    next_pwr   = PWR_ENTERING;
                    next_timer = TIMER_W'(SLEEP_ENTRY_CYCLES - 1);
                end
                // Wake while awake leaves standby as is
            end
            PWR_ENTERING: begin
                if (timer == '0) begin
                    next_pwr = PWR_SLEEP;
                end else begin
                    next_timer = timer - TIMER_W'(1);
                end
            end
            PWR_SLEEP: begin
                if (wake_req) begin
                    next_pwr   = PWR_WAKING;
                    next_timer = TIMER_W'(WAKE_CYCLES - 1);
                end
            end
            PWR_WAKING: begin
                if (timer == '0) begin
                    next_pwr = PWR_STANDBY;
                end else begin
                    next_timer = timer - TIMER_W'(1);
                end
            end
            default: next_pwr = PWR_STANDBY;
        endcase
    end

    // Reset always lands in standby
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr        <= PWR_STANDBY;
            timer      <= '0;
            deep_sleep <= 1'b0;
            standby    <= 1'b1;
        end else begin
            pwr        <= next_pwr;
            timer      <= next_timer;
            deep_sleep <= (next_pwr == PWR_SLEEP);
            standby    <= (next_pwr == PWR_STANDBY);
        end
    end

endmodule : fsid_core

// ==== fsid_core_properties.sv ====
// Checker: power-state timing and line drive of the sleep and ID block
`timescale 1ns/1ps
module fsid_core_properties
    import fsid_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic [3:0] io_in,
    input wire logic       write_busy_flag,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n,
    input wire logic       deep_sleep,
    input wire logic       standby
);
    logic [15:0] wait_cnt, next_wait_cnt;
    logic [3:0]  rise_cnt, next_rise_cnt, busy_age, next_busy_age;
    logic        sclk_d, busy_frm, next_busy_frm;

    // Transition length, rising link edges per frame, busy age
    always_comb begin
        next_wait_cnt = (standby || deep_sleep) ? 16'h0000 : wait_cnt + 16'h0001;
        next_rise_cnt = cs_n ? 4'h0 : rise_cnt + 4'((sclk && !sclk_d) && rise_cnt != 4'hF);
        next_busy_age = write_busy_flag ? busy_age + 4'(busy_age != 4'hF) : 4'h0;
        next_busy_frm = cs_n ? (busy_age == 4'hF) : busy_frm;
    end

    // Helper registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= 16'h0000;
            rise_cnt <= 4'h0;
            busy_age <= 4'h0;
            sclk_d   <= 1'b1;
            busy_frm <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            rise_cnt <= next_rise_cnt;
            busy_age <= next_busy_age;
            sclk_d   <= sclk;
            busy_frm <= next_busy_frm;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_deselected;
        cs_n [*8];
    endsequence
    sequence s_sleep_begins;
        !deep_sleep ##1 deep_sleep;
    endsequence
    sequence s_wake_ends;
        !standby ##1 standby;
    endsequence

    AST_RESET_STANDBY: assert property ($rose(rstn) |-> standby && !deep_sleep)
        else $error("power state wrong after reset");
    AST_IDLE_RELEASE: assert property (s_deselected |-> io_oe_n == 4'hF)
        else $error("line driven while deselected");
    AST_CMD_FIRST: assert property (io_oe_n != 4'hF && !cs_n |-> rise_cnt >= 4'h8)
        else $error("line driven before command byte");
    AST_FALL_LAUNCH: assert property ($changed(io_out) && io_oe_n != 4'hF |-> !sclk)
        else $error("output changed outside low clock phase");
    AST_SLEEP_QUIET: assert property (deep_sleep |-> io_oe_n[0] && io_oe_n[3:2] == 2'h3)
        else $error("asleep device drives a line");
    AST_BUSY_QUIET: assert property (busy_frm |-> io_oe_n == 4'hF)
        else $error("frame answered while busy");
    AST_ENTRY_DELAY: assert property (s_sleep_begins |->
        $past(wait_cnt) >= 16'h016D && $past(wait_cnt) <= 16'h0181)
        else $error("sleep entry delay wrong");
    AST_WAKE_DELAY: assert property (s_wake_ends |->
        $past(wait_cnt) >= 16'h03DE && $past(wait_cnt) <= 16'h03F2)
        else $error("wake delay wrong");
    AST_DROP_ON_DESELECT: assert property ($fell(standby) |-> cs_n && !deep_sleep)
        else $error("standby left inside a frame");
endmodule : fsid_core_properties

bind fsid_core fsid_core_properties u_props (
    .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .write_busy_flag(write_busy_flag), .io_out(io_out), .io_oe_n(io_oe_n),
    .deep_sleep(deep_sleep), .standby(standby));

// ==== fsid_host_model.sv ====
// Partner model: host controller framing commands on the serial link
`timescale 1ns/1ps
module fsid_host_model
    import fsid_pkg::*;
(
    input  wire logic       core_clk,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe_n
);
    logic [3:0] host_val;
    logic [7:0] got[$];
    int         drive_seen = 0;
    int         drive_base;

    // Deselected, link clock parked high between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        host_val = 4'h0;
        drive_base = 0;
    end

    // Line level: device where enabled, else host value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = io_oe_n[i] ? host_val[i] : io_out[i];
        end
    end

    // Count cycles in which the device drives a line
    always @(posedge core_clk) begin
        if (io_oe_n != 4'hF) begin
            drive_seen <= drive_seen + 1;
        end
    end

    // n link clocks of w bits; lines toggle when released
    task automatic xfer(input logic [7:0] tx, input int w, input int n, input bit rd,
                        output logic [7:0] rx);
        logic [3:0] mask;
        mask = 4'hF >> (4 - w);
        rx = 8'h00;
        for (int k = 0; k < n; k++) begin
            sclk <= 1'b0;
            host_val <= rd ? ~host_val : 4'((tx >> (8 - w * (k + 1))) & mask);
            repeat (10) @(posedge core_clk);
            sclk <= 1'b1;
            rx = (rx << w) | 8'((w == 1) ? io_in[1] : (io_in & mask));
            repeat (10) @(posedge core_clk);
        end
    endtask : xfer

    // Whole frame: command, preamble, read bytes, optional stray clocks
    task automatic frame(input logic [7:0] cmd, input int w, input int npre,
                         input logic [7:0] adr, input int nrd, input int extra);
        logic [7:0] r;
        got.delete();
        @(posedge core_clk);
        drive_base = drive_seen;
        cs_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        xfer(cmd, 1, 8, 1'b0, r);
        for (int i = 0; i < npre; i++) begin
            xfer((i == npre - 1) ? adr : 8'h00, w, 8 / w, 1'b0, r);
        end
        for (int i = 0; i < nrd; i++) begin
            xfer(8'h00, w, 8 / w, 1'b1, r);
            got.push_back(r);
        end
        if (extra > 0) begin
            xfer(8'h00, 1, extra, 1'b0, r);
        end
        cs_n <= 1'b1;
        repeat (30) @(posedge core_clk);
    endtask : frame
endmodule : fsid_host_model

// ==== flash_sleep_and_id_readout_tb.sv ====
// Testbench: sleep, wake, signature and ID readout
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t ns: got %0h expected %0h", $time, a, b); end end
module flash_sleep_and_id_readout_tb
    import fsid_pkg::*;
;
    logic       core_clk, rstn, write_busy_flag, cs_n, sclk, deep_sleep, standby;
    logic [3:0] io_in, io_out, io_oe_n;
    logic [7:0] id_cmd[3] = '{CMD_ID_SINGLE, CMD_ID_DUAL, CMD_ID_QUAD};
    int         err_count, n_tests, seed, m;

    fsid_core uut (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .write_busy_flag(write_busy_flag), .io_out(io_out),
        .io_oe_n(io_oe_n), .deep_sleep(deep_sleep), .standby(standby));
    fsid_host_model u_host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));

    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Expected ID byte at stream position k
    function automatic logic [7:0] id_exp(input logic [7:0] adr, input int k);
        return ((adr == ADDR_DEV_FIRST) ^ k[0]) ? DEV_ID_VALUE : MFR_ID_VALUE;
    endfunction : id_exp

    // One ID read frame and its byte checks
    task automatic id_read(input int mode, input logic [7:0] adr, input int n);
        u_host.frame(id_cmd[mode], 1 << mode, 3, adr, n, 0);
        for (int k = 0; k < n; k++) `CHK(u_host.got[k], id_exp(adr, k))
    endtask : id_read

    // Counts and verdict
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Hang guard
    initial begin
        #400000;
        err_count++;
        $display("unexpected at %0t ns: run hung", $time);
        give_verdict();
    end

    // Main sequence
    initial begin
        seed = 32'hF071;
        err_count = 0;
        n_tests = 0;
        rstn = 1'b0;
        write_busy_flag = 1'b0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK({standby, deep_sleep, io_oe_n}, 6'h2F)
        for (int i = 0; i < 3; i++) begin
            id_read(i, 8'h00, 3);
            id_read(i, ADDR_DEV_FIRST, 4);
        end
        repeat (6) begin
            m = $unsigned($random(seed)) % 3;
            id_read(m, ($random(seed) & 1) ? ADDR_DEV_FIRST : 8'($random(seed)),
                    $unsigned($random(seed)) % 4 + 1);
        end
        // Signature while awake repeats and keeps standby; IDs above use the ID read
        u_host.frame(CMD_WAKE_SIGNATURE, 1, 0, 8'h00, 3, 0);
        for (int k = 0; k < 3; k++) `CHK(u_host.got[k], SIGNATURE_VALUE)
        `CHK({standby, deep_sleep}, 2'h2)
        // Stray clock after sleep byte, then frames while busy: all ignored
        u_host.frame(CMD_DEEP_SLEEP, 1, 0, 8'h00, 0, 1);
        write_busy_flag <= 1'b1;
        repeat (20) @(posedge core_clk);
        u_host.frame(CMD_ID_SINGLE, 1, 3, 8'h00, 2, 0);
        `CHK(u_host.drive_seen - u_host.drive_base, 0)
        u_host.frame(CMD_DEEP_SLEEP, 1, 0, 8'h00, 0, 0);
        repeat (500) @(posedge core_clk);
        `CHK({standby, deep_sleep}, 2'h2)
        write_busy_flag <= 1'b0;
        repeat (20) @(posedge core_clk);
        // Valid sleep entry waits out the entry delay
        u_host.frame(CMD_DEEP_SLEEP, 1, 0, 8'h00, 0, 0);
        `CHK({standby, deep_sleep}, 2'h0)
        repeat (300) @(posedge core_clk);
        `CHK(deep_sleep, 1'b0)
        repeat (80) @(posedge core_clk);
        `CHK({standby, deep_sleep}, 2'h1)
        // Asleep: ID read ignored, wake refused while busy
        u_host.frame(CMD_ID_SINGLE, 1, 3, 8'h00, 2, 0);
        `CHK(u_host.drive_seen - u_host.drive_base, 0)
        write_busy_flag <= 1'b1;
        repeat (20) @(posedge core_clk);
        u_host.frame(CMD_WAKE_SIGNATURE, 1, 0, 8'h00, 1, 0);
        repeat (1100) @(posedge core_clk);
        `CHK({standby, deep_sleep}, 2'h1)
        write_busy_flag <= 1'b0;
        repeat (20) @(posedge core_clk);
        // Wake with signature: standby only after the wake delay
        u_host.frame(CMD_WAKE_SIGNATURE, 1, 0, 8'h00, 1, 0);
        `CHK(u_host.got[0], SIGNATURE_VALUE)
        repeat (900) @(posedge core_clk);
        `CHK({standby, deep_sleep}, 2'h0)
        repeat (150) @(posedge core_clk);
        `CHK({standby, deep_sleep}, 2'h2)
        id_read(0, 8'h00, 2);
        give_verdict();
    end
endmodule : flash_sleep_and_id_readout_tb
